//--- logic/usblc_pkg.sv
package usblc_pkg;
   // register indices; byte address is four times the index
   localparam logic [31:0] ATTR_IDX = 32'h400A0360;
   localparam logic [31:0] CTL_IDX = 32'h400A0362;
   localparam logic [31:0] IEN_IDX = 32'h400A0363;
   localparam logic [31:0] FLAGS_IDX = 32'h400A0364;
   localparam int unsigned DEC_LSB = 2;
   localparam int unsigned DEC_W = 8;
   // control fields
   localparam int unsigned CTL_ARM_BIT = 0;
   localparam int unsigned CTL_WAKE_BIT = 1;
   localparam int unsigned CTL_LVL_LSB = 2;
   localparam int unsigned CTL_NAK_BIT = 4;
   localparam logic [1:0] LVL_NONE_A = 2'h0;
   localparam logic [1:0] LVL_NONE_B = 2'h1;
   localparam logic [1:0] LVL_STALL = 2'h2;
   localparam logic [1:0] LVL_FULL = 2'h3;
   localparam logic [1:0] LVL_RST = 2'h0;
   localparam logic [5:0] IEN_RST = 6'h00;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   localparam logic [15:0] ATTR_RST = 16'h0000;
   // event bit positions, shared by flags and enables
   localparam int unsigned NEV = 6;
   localparam int unsigned EV_STALL = 0;
   localparam int unsigned EV_NYET = 1;
   localparam int unsigned EV_ACK = 2;
   localparam int unsigned EV_PEND = 3;
   localparam int unsigned EV_RES = 4;
   localparam int unsigned EV_ERR = 5;
   // requested link state field of the attribute word
   localparam int unsigned LS_LSB = 0;
   localparam logic [3:0] LS_L1 = 4'h1;
   // remote wake signalling time
   localparam int unsigned CLK_NS = 100;
   localparam int unsigned WAKE_NS = 50000;
   localparam int unsigned WAKE_CYC = WAKE_NS / CLK_NS;
   typedef enum logic [1:0] {
      RESP_NONE, RESP_STALL, RESP_NYET, RESP_ACK
   } usblc_resp_e;
endpackage : usblc_pkg

//--- logic/usblc_evt_if.sv
`timescale 1ns/1ps
interface usblc_evt_if;
   logic [5:0] evt;
   logic [5:0] clr;
   logic [5:0] enable;
   logic [5:0] flags;
   logic irq_n;
   modport ctrl (output evt, clr, enable, input flags, irq_n);
   modport flag (input evt, clr, enable, output flags, irq_n);
endinterface : usblc_evt_if

//--- logic/usblc_flags.sv
`timescale 1ns/1ps
module usblc_flags (
   input wire logic sys_clk, // clock
   input wire logic rst_n, // sync reset
   usblc_evt_if.flag ev // events, clears, enables
);
   logic [5:0] flags_ff;
   logic [5:0] nxt_flags;

   // a set in the clearing cycle survives
   assign nxt_flags = (flags_ff & ~ev.clr) | ev.evt;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flags_ff <= usblc_pkg::FLAGS_RST;
      end else begin
         flags_ff <= nxt_flags; // [R13] [R18]
      end
   end

   assign ev.flags = flags_ff;
   assign ev.irq_n = ~|(flags_ff & ev.enable); // [R13] [R18]

   property p_flag_set_wins;
      @(posedge sys_clk) disable iff (!rst_n)
      (ev.evt != 6'h00) |=> ((flags_ff & $past(ev.evt)) == $past(ev.evt));
   endproperty
   a_flag_set_wins: assert property (p_flag_set_wins) // [R13]
      else $error("event did not set its flag");

   property p_masked_quiet;
      @(posedge sys_clk) disable iff (!rst_n)
      ((flags_ff & ev.enable) == 6'h00) |-> ev.irq_n;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) // [R13]
      else $error("interrupt asserted with no enabled flag");
endmodule : usblc_flags

//--- logic/usblc_wake_timer.sv
`timescale 1ns/1ps
module usblc_wake_timer #(
   parameter int unsigned CYC = usblc_pkg::WAKE_CYC
) (
   input wire logic sys_clk, // clock
   input wire logic rst_n, // sync reset
   input wire logic start, // request pulse
   output logic busy, // resume being driven
   output logic done // pulse at the end
);
   localparam int CNT_W = $clog2(CYC + 1);
   logic [CNT_W-1:0] cnt_ff;
   logic busy_ff;
   logic done_ff;

   // a start while busy is dropped, so a run is never cut or stretched
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (!busy_ff && start) begin
            cnt_ff <= CNT_W'(CYC - 1); // [R6]
            busy_ff <= 1'b1;
         end else if (busy_ff && cnt_ff == '0) begin
            busy_ff <= 1'b0; // [R7]
            done_ff <= 1'b1;
         end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end

   assign busy = busy_ff;
   assign done = done_ff;
endmodule : usblc_wake_timer

//--- logic/usblc_lpm_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// R1: suspend nak forces NAK except LPM
// R2: nak starts after LPM suspend, holds till cleared
// R3: level 00/01 gives no LPM response
// R4: level 10 answers LPM with STALL
// R5: level 11 answers NYET or ACK; code answers STALL to a reserved link state
// R6: wake write drives resume for 50 us
// R7: wake bit clears itself after signalling
// R8: armed bit moves to L1 on next LPM
// R9: arm only effective at level 11
// R10: arm and level settable in one write
// R11: armed, empty FIFOs: ACK, disarm, flag
// R12: armed, data pending: NYET, stay armed, flag
// R13: enables gate interrupt only, flags still set
// R14: six enables map to six LPM events
// R15: writing wake zero has no effect
// R16: attributes captured on ACK, else held; code also captures on a reserved link state STALL and takes software writes
// R17: host asks L1 with link state 0001
// R18: flags clear on read, drive active-low irq
module usblc_lpm_ctrl (
   input wire logic sys_clk, // 10 MHz clock
   input wire logic rst_n, // sync reset
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write
   input wire logic [31:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // wishbone ack
   input wire logic lpm_tok_valid, // LPM token received
   input wire logic [15:0] lpm_tok_attr, // LPM packet attributes
   input wire logic tx_data_pending, // any tx FIFO not empty
   input wire logic bus_resumed, // resume seen on bus
   output logic lpm_resp_valid, // response strobe
   output usblc_pkg::usblc_resp_e lpm_resp, // response kind
   output logic nak_all, // NAK non-LPM traffic
   output logic resume_drive, // drive resume signalling
   output logic l1_enter, // enter L1 pulse
   output logic usb_int_n // LPM interrupt, low active
);
   logic req;
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic [31:0] nxt_rdat;
   logic wr_now;
   logic rd_now;
   logic wr_ctl;
   logic wr_ien;
   logic wr_attr_lo;
   logic wr_attr_hi;
   logic rd_flags;
   logic nak_en_ff;
   logic [1:0] level_ff;
   logic arm_ff;
   logic [5:0] ien_ff;
   logic [15:0] attr_ff;
   logic susp_ff;
   logic nak_ff;
   logic resp_v_ff;
   usblc_pkg::usblc_resp_e resp_ff;
   usblc_pkg::usblc_resp_e nxt_resp;
   logic [5:0] evt_ff;
   logic [5:0] nxt_evt;
   logic arm_clr;
   logic cap;
   logic l1_ff;
   logic wake_go;
   logic wake_busy;
   logic wake_done;
   logic [7:0] ctl_rd;

   usblc_evt_if ev ();

   function automatic logic hit(input logic [31:0] adr,
                                input logic [31:0] idx);
      hit = adr[usblc_pkg::DEC_LSB +: usblc_pkg::DEC_W]
            == idx[usblc_pkg::DEC_W-1:0];
   endfunction : hit

   // ---- wishbone slave: ack one cycle after the request
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_now = req & wb_we_i & ack_ff;
   assign rd_now = req & ~wb_we_i & ack_ff;
   assign wr_ctl = wr_now & wb_sel_i[0]
                   & hit(wb_adr_i, usblc_pkg::CTL_IDX);
   assign wr_ien = wr_now & wb_sel_i[0]
                   & hit(wb_adr_i, usblc_pkg::IEN_IDX);
   assign wr_attr_lo = wr_now & wb_sel_i[0]
                       & hit(wb_adr_i, usblc_pkg::ATTR_IDX);
   assign wr_attr_hi = wr_now & wb_sel_i[1]
                       & hit(wb_adr_i, usblc_pkg::ATTR_IDX);
   assign rd_flags = rd_now & hit(wb_adr_i, usblc_pkg::FLAGS_IDX);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   assign ctl_rd = {3'h0, nak_en_ff, level_ff, wake_busy, arm_ff};

   // unmapped words read as zero and ignore writes
   always_comb begin
      nxt_rdat = 32'h0000_0000;
      if (hit(wb_adr_i, usblc_pkg::CTL_IDX)) begin
         nxt_rdat[7:0] = ctl_rd;
      end else if (hit(wb_adr_i, usblc_pkg::IEN_IDX)) begin
         nxt_rdat[5:0] = ien_ff;
      end else if (hit(wb_adr_i, usblc_pkg::FLAGS_IDX)) begin
         nxt_rdat[5:0] = ev.flags;
      end else if (hit(wb_adr_i, usblc_pkg::ATTR_IDX)) begin
         nxt_rdat[15:0] = attr_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdat_ff <= 32'h0000_0000;
      end else if (req && !ack_ff) begin
         rdat_ff <= nxt_rdat;
      end
   end

   assign wb_dat_o = rdat_ff;
   assign wb_ack_o = ack_ff;

   // only bits already shown to software are cleared
   assign ev.clr = rd_flags ? rdat_ff[5:0] : 6'h00; // [R18]

   // ---- control register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         nak_en_ff <= 1'b0;
         level_ff <= usblc_pkg::LVL_RST;
      end else if (wr_ctl) begin
         nak_en_ff <= wb_dat_i[usblc_pkg::CTL_NAK_BIT];
         level_ff <= wb_dat_i[usblc_pkg::CTL_LVL_LSB +: 2]; // [R10]
      end
   end

   // hardware disarm wins over a software write in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         arm_ff <= 1'b0;
      end else if (arm_clr) begin
         arm_ff <= 1'b0; // [R11]
      end else if (wr_ctl) begin
         arm_ff <= wb_dat_i[usblc_pkg::CTL_ARM_BIT]; // [R8] [R10]
      end
   end

   // only a written one starts the timer
   assign wake_go = wr_ctl & wb_dat_i[usblc_pkg::CTL_WAKE_BIT]; // [R15]

   usblc_wake_timer u_wake (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(wake_go),
      .busy(wake_busy),
      .done(wake_done)
   );

   assign resume_drive = wake_busy; // [R6]

   // ---- interrupt enables
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ien_ff <= usblc_pkg::IEN_RST;
      end else if (wr_ien) begin
         ien_ff <= wb_dat_i[usblc_pkg::NEV-1:0]; // [R14]
      end
   end

   assign ev.enable = ien_ff; // [R13]

   // ---- LPM token response
   always_comb begin
      nxt_resp = usblc_pkg::RESP_NONE;
      nxt_evt = 6'h00;
      arm_clr = 1'b0;
      cap = 1'b0;
      if (lpm_tok_valid) begin
         unique case (level_ff)
            usblc_pkg::LVL_NONE_A, usblc_pkg::LVL_NONE_B: begin
               nxt_resp = usblc_pkg::RESP_NONE; // [R3]
            end
            usblc_pkg::LVL_STALL: begin
               nxt_resp = usblc_pkg::RESP_STALL; // [R4]
               nxt_evt[usblc_pkg::EV_STALL] = 1'b1;
            end
            usblc_pkg::LVL_FULL: begin
               if (lpm_tok_attr[usblc_pkg::LS_LSB +: 4]
                   != usblc_pkg::LS_L1) begin
                  // reserved link state: refuse, keep payload
                  nxt_resp = usblc_pkg::RESP_STALL; // [R17]
                  nxt_evt[usblc_pkg::EV_ERR] = 1'b1;
                  cap = 1'b1;
               end else if (!arm_ff) begin
                  nxt_resp = usblc_pkg::RESP_NYET; // [R5] [R9]
                  nxt_evt[usblc_pkg::EV_NYET] = 1'b1;
               end else if (tx_data_pending) begin
                  nxt_resp = usblc_pkg::RESP_NYET; // [R12]
                  nxt_evt[usblc_pkg::EV_PEND] = 1'b1;
               end else begin
                  nxt_resp = usblc_pkg::RESP_ACK; // [R11]
                  nxt_evt[usblc_pkg::EV_ACK] = 1'b1;
                  arm_clr = 1'b1;
                  cap = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         resp_v_ff <= 1'b0;
         resp_ff <= usblc_pkg::RESP_NONE;
         l1_ff <= 1'b0;
      end else begin
         resp_v_ff <= lpm_tok_valid && level_ff[1];
         resp_ff <= nxt_resp;
         l1_ff <= arm_clr; // [R8]
      end
   end

   assign lpm_resp_valid = resp_v_ff;
   assign lpm_resp = resp_ff;
   assign l1_enter = l1_ff;

   // events go to the flags one cycle after the token
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         evt_ff <= 6'h00;
      end else begin
         evt_ff <= nxt_evt;
         evt_ff[usblc_pkg::EV_RES] <= bus_resumed | wake_done;
      end
   end

   assign ev.evt = evt_ff; // [R14]

   usblc_flags u_flags (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ev(ev)
   );

   assign usb_int_n = ev.irq_n; // [R18]

   // ---- attribute capture
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         attr_ff <= usblc_pkg::ATTR_RST;
      end else if (cap) begin
         attr_ff <= lpm_tok_attr; // [R16]
      end else begin
         if (wr_attr_lo) begin
            attr_ff[7:0] <= wb_dat_i[7:0];
         end
         if (wr_attr_hi) begin
            attr_ff[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // ---- LPM suspend and NAK hold
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         susp_ff <= 1'b0;
      end else if (arm_clr) begin
         susp_ff <= 1'b1;
      end else if (bus_resumed || wake_done) begin
         susp_ff <= 1'b0;
      end
   end

   // once caught, the hold outlives the suspend until software clears
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         nak_ff <= 1'b0;
      end else if (!nak_en_ff) begin
         nak_ff <= 1'b0; // [R2]
      end else if (susp_ff) begin
         nak_ff <= 1'b1; // [R2]
      end
   end

   assign nak_all = nak_ff; // [R1]

   // ---- checks
   sequence s_tok_level(logic [1:0] lv);
      lpm_tok_valid && level_ff == lv;
   endsequence

   sequence s_armed_tok(logic pend);
      lpm_tok_valid && level_ff == usblc_pkg::LVL_FULL && arm_ff
      && lpm_tok_attr[3:0] == usblc_pkg::LS_L1
      && tx_data_pending == pend;
   endsequence

   property p_no_resp;
      @(posedge sys_clk) disable iff (!rst_n)
      (lpm_tok_valid && !level_ff[1]) |=> !lpm_resp_valid;
   endproperty
   a_no_resp: assert property (p_no_resp) // [R3]
      else $error("response given at disabled level");

   property p_stall;
      @(posedge sys_clk) disable iff (!rst_n)
      s_tok_level(usblc_pkg::LVL_STALL) |=>
         lpm_resp_valid && lpm_resp == usblc_pkg::RESP_STALL
         ##1 ev.flags[usblc_pkg::EV_STALL];
   endproperty
   a_stall: assert property (p_stall) // [R4]
      else $error("level 10 did not stall and flag");

   property p_unarmed_nyet;
      @(posedge sys_clk) disable iff (!rst_n)
      (s_tok_level(usblc_pkg::LVL_FULL) and
       (!arm_ff && lpm_tok_attr[3:0] == usblc_pkg::LS_L1))
      |=> lpm_resp == usblc_pkg::RESP_NYET && !l1_enter;
   endproperty
   a_unarmed_nyet: assert property (p_unarmed_nyet) // [R5]
      else $error("unarmed LPM not answered NYET");

   property p_ack;
      @(posedge sys_clk) disable iff (!rst_n)
      s_armed_tok(1'b0) |=>
         lpm_resp == usblc_pkg::RESP_ACK && !arm_ff && l1_enter
         && attr_ff == $past(lpm_tok_attr)
         ##1 ev.flags[usblc_pkg::EV_ACK];
   endproperty
   a_ack: assert property (p_ack) // [R11]
      else $error("armed empty LPM not acked");

   property p_pend;
      @(posedge sys_clk) disable iff (!rst_n)
      s_armed_tok(1'b1) |=>
         lpm_resp == usblc_pkg::RESP_NYET && arm_ff && !l1_enter
         ##1 ev.flags[usblc_pkg::EV_PEND];
   endproperty
   a_pend: assert property (p_pend) // [R12]
      else $error("pending data case wrong");

   property p_attr_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (!cap && !wr_attr_lo && !wr_attr_hi) |=> $stable(attr_ff);
   endproperty
   a_attr_hold: assert property (p_attr_hold) // [R16]
      else $error("attributes changed without cause");

   property p_wake_len;
      @(posedge sys_clk) disable iff (!rst_n)
      (wake_go && !resume_drive) |=>
         resume_drive [*8] ##[492:492] resume_drive ##1 !resume_drive;
   endproperty
   a_wake_len: assert property (p_wake_len) // [R6] [R7]
      else $error("resume not driven for 500 cycles");

   property p_wake_zero;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_ctl && !wb_dat_i[1] && !resume_drive) |=> !resume_drive;
   endproperty
   a_wake_zero: assert property (p_wake_zero) // [R15]
      else $error("zero write started resume");

   property p_nak_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (nak_all && nak_en_ff) |=> nak_all;
   endproperty
   a_nak_hold: assert property (p_nak_hold) // [R2]
      else $error("nak dropped while enabled");

   property p_rd_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      (rd_flags && ev.evt == 6'h00) |=> (ev.flags & $past(ev.clr)) == 6'h00;
   endproperty
   a_rd_clear: assert property (p_rd_clear) // [R18]
      else $error("read flags not cleared");
endmodule : usblc_lpm_ctrl

//--- tb/usblc_host_model.sv
`timescale 1ns/1ps
module usblc_host_model (
   input wire logic sys_clk, // clock
   output logic tok_valid, // token strobe
   output logic [15:0] tok_attr, // token payload
   output logic resumed, // resume pulse
   input wire logic resp_valid, // answer strobe
   input wire usblc_pkg::usblc_resp_e resp // answer kind
);
   logic [1:0] last_resp;
   int n_resp;
   initial begin
      tok_valid = 1'b0;
      tok_attr = 16'h0000;
      resumed = 1'b0;
      last_resp = 2'h0;
      n_resp = 0;
   end
   // no answer means the host transaction simply times out
   always @(posedge sys_clk) begin
      if (resp_valid === 1'b1) begin
         last_resp <= resp;
         n_resp <= n_resp + 1;
      end
   end
   task automatic send(input logic [11:0] hi, input logic [3:0] ls);
      @(posedge sys_clk);
      tok_valid <= 1'b1;
      tok_attr <= {hi, ls};
      @(posedge sys_clk);
      tok_valid <= 1'b0;
      // stale payload must not look valid after the strobe
      tok_attr <= ~{hi, ls};
   endtask : send
   task automatic send_l1(input logic [11:0] hi);
      send(hi, usblc_pkg::LS_L1);
   endtask : send_l1
   task automatic resume();
      @(posedge sys_clk);
      resumed <= 1'b1;
      @(posedge sys_clk);
      resumed <= 1'b0;
   endtask : resume
endmodule : usblc_host_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic sys_clk, rst_n, cyc, stb, we, ack, tok_v, bus_res, tx_pend;
   logic rsp_v, nak_all, res_drv, l1_enter, int_n;
   logic [31:0] adr, dat_i, dat_o, q;
   logic [3:0] sel;
   logic [15:0] tok_a;
   usblc_pkg::usblc_resp_e rsp;
   int n_mismatch, n_tests, n_l1, cnt;
   logic [5:0] expfl [4] = '{6'h00, 6'h00, 6'h01, 6'h02};
   int expn [4] = '{0, 0, 1, 1};
   logic [1:0] exprsp [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
   usblc_lpm_ctrl i_usblc_lpm_ctrl (.sys_clk(sys_clk), .rst_n(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .lpm_tok_valid(tok_v), .lpm_tok_attr(tok_a),
      .tx_data_pending(tx_pend), .bus_resumed(bus_res),
      .lpm_resp_valid(rsp_v), .lpm_resp(rsp), .nak_all(nak_all),
      .resume_drive(res_drv), .l1_enter(l1_enter), .usb_int_n(int_n));
   usblc_host_model i_usblc_host_model (.sys_clk(sys_clk),
      .tok_valid(tok_v), .tok_attr(tok_a), .resumed(bus_res),
      .resp_valid(rsp_v), .resp(rsp));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (l1_enter === 1'b1) n_l1 <= n_l1 + 1;
   end
   task automatic conclude();
      $display("mismatches %0d tests %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one classic cycle; ack and read data taken at the edge ack stands
   task automatic wb(input logic w, input logic [31:0] idx,
                     input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= idx << 2;
      sel <= 4'hF;
      dat_i <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (ack === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         conclude();
      end
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task automatic rd(input logic [31:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 32'h00000000);
      check(q, exp);
   endtask : rd
   task automatic tok(input logic [11:0] hi, input logic [3:0] ls,
                      input logic pend, input int en, input logic [1:0] er);
      int n0;
      tx_pend <= pend;
      n0 = i_usblc_host_model.n_resp;
      i_usblc_host_model.send(hi, ls);
      repeat (3) @(posedge sys_clk);
      check(i_usblc_host_model.n_resp - n0, en);
      if (en != 0) check({30'h0, i_usblc_host_model.last_resp}, {30'h0, er});
   endtask : tok
   initial begin
      {rst_n, cyc, stb, we, tx_pend} = 5'h00;
      adr = 32'h00000000;
      dat_i = 32'h00000000;
      sel = 4'hF;
      {n_mismatch, n_tests, n_l1, cnt} = '0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      check({31'h0, int_n}, 32'h1);
      rd(usblc_pkg::ATTR_IDX, 32'h0);
      rd(usblc_pkg::CTL_IDX, 32'h0);
      rd(usblc_pkg::IEN_IDX, 32'h0);
      rd(usblc_pkg::FLAGS_IDX, 32'h0);
      rd(32'h400A0365, 32'h0);
      wb(1'b1, usblc_pkg::IEN_IDX, 32'hFF);
      rd(usblc_pkg::IEN_IDX, 32'h3F);
      for (int l = 0; l < 4; l++) begin
         wb(1'b1, usblc_pkg::CTL_IDX, l << 2);
         tok(12'h123, usblc_pkg::LS_L1, 1'b0, expn[l], exprsp[l]);
         check({31'h0, int_n}, {31'h0, expfl[l] == 6'h00});
         rd(usblc_pkg::FLAGS_IDX, {26'h0, expfl[l]});
         rd(usblc_pkg::FLAGS_IDX, 32'h0);
      end
      wb(1'b1, usblc_pkg::IEN_IDX, 32'h3E);
      wb(1'b1, usblc_pkg::CTL_IDX, 32'h08);
      tok(12'h123, usblc_pkg::LS_L1, 1'b0, 1, 2'h1);
      check({31'h0, int_n}, 32'h1);
      wb(1'b1, usblc_pkg::IEN_IDX, 32'h01);
      repeat (2) @(posedge sys_clk);
      check({31'h0, int_n}, 32'h0);
      rd(usblc_pkg::FLAGS_IDX, 32'h01);
      wb(1'b1, usblc_pkg::CTL_IDX, 32'h0C);
      tok(12'hABC, 4'h2, 1'b0, 1, 2'h1);
      rd(usblc_pkg::FLAGS_IDX, 32'h20);
      rd(usblc_pkg::ATTR_IDX, 32'hABC2);
      wb(1'b1, usblc_pkg::CTL_IDX, 32'h1D);
      repeat (2) @(posedge sys_clk);
      check({31'h0, nak_all}, 32'h0);
      tok(12'h456, usblc_pkg::LS_L1, 1'b1, 1, 2'h2);
      rd(usblc_pkg::CTL_IDX, 32'h1D);
      rd(usblc_pkg::FLAGS_IDX, 32'h08);
      rd(usblc_pkg::ATTR_IDX, 32'hABC2);
      tok(12'h789, usblc_pkg::LS_L1, 1'b0, 1, 2'h3);
      check(n_l1, 1);
      rd(usblc_pkg::CTL_IDX, 32'h1C);
      rd(usblc_pkg::FLAGS_IDX, 32'h04);
      rd(usblc_pkg::ATTR_IDX, 32'h7891);
      check({31'h0, nak_all}, 32'h1);
      i_usblc_host_model.resume();
      repeat (2) @(posedge sys_clk);
      check({31'h0, nak_all}, 32'h1);
      rd(usblc_pkg::FLAGS_IDX, 32'h10);
      wb(1'b1, usblc_pkg::CTL_IDX, 32'h09);
      repeat (2) @(posedge sys_clk);
      check({31'h0, nak_all}, 32'h0);
      tok(12'h123, usblc_pkg::LS_L1, 1'b0, 1, 2'h1);
      check(n_l1, 1);
      rd(usblc_pkg::CTL_IDX, 32'h09);
      rd(usblc_pkg::FLAGS_IDX, 32'h01);
      fork
         for (int j = 0; j < 800; j++) begin
            @(negedge sys_clk);
            if (res_drv === 1'b1) cnt++;
         end
         begin
            wb(1'b1, usblc_pkg::CTL_IDX, 32'h0E);
            repeat (100) @(posedge sys_clk);
            wb(1'b1, usblc_pkg::CTL_IDX, 32'h0C);
            rd(usblc_pkg::CTL_IDX, 32'h0E);
         end
      join
      check(cnt, usblc_pkg::WAKE_CYC);
      rd(usblc_pkg::CTL_IDX, 32'h0C);
      rd(usblc_pkg::FLAGS_IDX, 32'h10);
      conclude();
   end
endmodule : testbench
